// ===== pcps_params.svh
// Constants of the clock and power sequencer.
`ifndef PCPS_PARAMS_SVH
`define PCPS_PARAMS_SVH

// APB register byte addresses.
`define PCPS_ADDR_CTRL 12'h000
`define PCPS_ADDR_STAT 12'h004
`define PCPS_ADDR_OTG 12'h008
`define PCPS_ADDR_CFG 12'h00C

// Control register fields.
`define PCPS_CTRL_RAIL_STEPS 0
`define PCPS_CTRL_LOCK_TIME 2

// Status register fields.
`define PCPS_ST_STATE_LSB 0
`define PCPS_ST_STATE_MSB 6
`define PCPS_ST_CLKOUT 8
`define PCPS_ST_REFDET 9
`define PCPS_ST_STRAP 10
`define PCPS_ST_RESET 11
`define PCPS_ST_PLLRUN 12
`define PCPS_ST_PLLLOCK 13
`define PCPS_ST_DIR 14
`define PCPS_ST_CHGMODE 15

// OTG control reset value: pulldowns on, no VBUS drive.
`define PCPS_OTG_RESET 4'h6
`define PCPS_OTG_DRVVBUS 0
`define PCPS_OTG_DPPD 1
`define PCPS_OTG_DMPD 2
`define PCPS_OTG_DRVEXT 3

// Timing.
`define PCPS_CLK_MHZ 250
`define PCPS_PLL_LOCK_US 10
`define PCPS_PLL_LOCK_CYC (`PCPS_PLL_LOCK_US * `PCPS_CLK_MHZ)
`define PCPS_RAIL_STEP_NS 40
`define PCPS_RAIL_STEP_CYC ((`PCPS_RAIL_STEP_NS * `PCPS_CLK_MHZ + 999) / 1000)
`define PCPS_RAIL_STEPS 3
`define PCPS_REF_EDGES 8'h08
`define PCPS_REF_WATCH_CYC 16'h0100
`define PCPS_PLL_RATIO_19M2 8'h19
`define PCPS_PLL_RATIO_26M 8'h12
`define PCPS_PLL_RATIO_ULPI 8'h08

`endif

// ===== pcps_pkg.sv
// Types shared by the clock and power sequencer.
package pcps_pkg;
  typedef enum logic [6:0] {
    PCPS_OFF = 7'h01,
    PCPS_RAMP = 7'h02,
    PCPS_RST = 7'h04,
    PCPS_LOCK = 7'h08,
    PCPS_RUN = 7'h10,
    PCPS_CRAMP = 7'h20,
    PCPS_CHG = 7'h40
  } pcps_state_e;

  typedef struct packed {
    logic vbat_ok;
    logic vio_ok;
    logic vbus_ok;
    logic vbat_above_mntr;
    logic chip_select;
    logic chip_select_low;
    logic charger_detect_enable_low;
    logic freq_strap;
  } pcps_pins_s;

  typedef struct packed {
    logic internal_power_on_reset;
    logic pll_run;
    logic [7:0] pll_ratio;
    logic pll_ref_is_ulpi;
    logic active_power_state;
    logic charger_fsm_start;
  } pcps_core_s;
endpackage

// ===== pcps_sequencer.sv
// Clock configuration and power-up sequencer of a ULPI transceiver.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pcps_params.svh"

module pcps_sequencer #(
  parameter int LOCK_CYC = `PCPS_PLL_LOCK_CYC // PLL lock wait in cycles
) (
  input wire logic pclk, // APB clock, 250 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire pcps_pkg::pcps_pins_s pins, // Asynchronous supply and strap pins
  input wire logic reference_clock_input, // Reference clock pin
  input wire logic pll_locked, // Lock flag from the analog PLL
  input wire logic ulpi_clk_in, // ULPI clock pin, input side
  output logic ulpi_clk_out, // ULPI clock pin, output side
  output logic ulpi_clk_oe, // ULPI clock pin, drive enable
  output logic ulpi_dir, // ULPI direction output
  output logic [3:0] otg_ctrl, // OTG control bits to the PHY
  output pcps_pkg::pcps_core_s core // Controls to PLL and power domains
);
  import pcps_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pcps_pins_s pins_m;
  pcps_pins_s pins_s;
  logic ref_m;
  logic ref_s;
  logic ref_d;
  logic lock_m;
  logic lock_s;
  logic uclk_m;
  logic uclk_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_m <= '0;
      pins_s <= '0;
      ref_m <= 1'b0;
      ref_s <= 1'b0;
      ref_d <= 1'b0;
      lock_m <= 1'b0;
      lock_s <= 1'b0;
      uclk_m <= 1'b0;
      uclk_s <= 1'b0;
    end else begin
      pins_m <= pins;
      pins_s <= pins_m;
      ref_m <= reference_clock_input;
      ref_s <= ref_m;
      ref_d <= ref_s;
      lock_m <= pll_locked;
      lock_s <= lock_m;
      uclk_m <= ulpi_clk_in;
      uclk_s <= uclk_m;
    end
  end

  // ****************************************************************
  // Power-up conditions
  // ****************************************************************
  // Both select pins must agree, so the unused one must be tied to its active level.
  wire selected = pins_s.chip_select && !pins_s.chip_select_low;
  wire std_go = selected && pins_s.vbat_ok && pins_s.vio_ok;
  wire chg_go = !selected && pins_s.vbus_ok &&
    !pins_s.charger_detect_enable_low && pins_s.vbat_above_mntr;
  wire ref_rise = ref_s && !ref_d;

  // ****************************************************************
  // Reference clock activity detection
  // ****************************************************************
  // A grounded reference pin never toggles, so a window of edges separates
  // the two clock configurations; fewer than 8 glitches in one window are ignored.
  logic [7:0] ref_edges;
  logic [15:0] ref_watch;
  logic ref_active;
  wire watch_end = ref_watch == `PCPS_REF_WATCH_CYC;
  wire [7:0] next_ref_edges = watch_end ? 8'h00 :
    ref_edges + {7'h00, ref_rise};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_edges <= 8'h00;
      ref_watch <= 16'h0000;
      ref_active <= 1'b0;
    end else begin
      ref_watch <= watch_end ? 16'h0000 : ref_watch + 16'h0001;
      ref_edges <= next_ref_edges;
      // Output mode latched once activity is seen
      if (ref_edges >= `PCPS_REF_EDGES) begin
        ref_active <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  pcps_state_e state;
  pcps_state_e next_state;
  logic [15:0] step_cnt;
  logic [1:0] step_idx;
  logic [31:0] lock_cnt;
  logic strap;
  logic [1:0] rail_steps;
  logic lock_wait_en;
  logic uclk_d;
  logic div_tog;

  wire step_done = step_cnt == 16'(`PCPS_RAIL_STEP_CYC - 1);
  wire ramp_done = step_done && step_idx == rail_steps;
  wire lock_ok = lock_s && (!lock_wait_en || lock_cnt >= 32'(LOCK_CYC));

  always_comb begin
    next_state = state;
    case (state)
      PCPS_OFF: begin
        if (std_go) begin
          next_state = PCPS_RAMP;
        end else if (chg_go) begin
          next_state = PCPS_CRAMP;
        end
      end
      PCPS_RAMP: begin
        if (!std_go) begin
          next_state = PCPS_OFF;
        end else if (ramp_done) begin
          next_state = PCPS_RST;
        end
      end
      PCPS_RST: begin
        next_state = std_go ? PCPS_LOCK : PCPS_OFF;
      end
      PCPS_LOCK: begin
        if (!std_go) begin
          next_state = PCPS_OFF;
        end else if (lock_ok) begin
          next_state = PCPS_RUN;
        end
      end
      PCPS_RUN: begin
        if (!std_go) begin
          next_state = PCPS_OFF;
        end
      end
      PCPS_CRAMP: begin
        if (!chg_go) begin
          next_state = PCPS_OFF;
        end else if (ramp_done) begin
          next_state = PCPS_CHG;
        end
      end
      PCPS_CHG: begin
        if (!chg_go) begin
          next_state = PCPS_OFF;
        end
      end
      default: begin
        next_state = PCPS_OFF;
      end
    endcase
  end
  wire in_ramp = state == PCPS_RAMP || state == PCPS_CRAMP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PCPS_OFF;
      step_cnt <= 16'h0000;
      step_idx <= 2'h0;
      lock_cnt <= 32'h0000_0000;
      strap <= 1'b0;
    end else begin
      state <= next_state;
      step_cnt <= (!in_ramp || step_done) ? 16'h0000 : step_cnt + 16'h0001;
      if (!in_ramp) begin
        step_idx <= 2'h0;
      end else if (step_done) begin
        step_idx <= step_idx + 2'h1;
      end
      lock_cnt <= (state == PCPS_LOCK) ? lock_cnt + 32'h0000_0001 :
        32'h0000_0000;
      // Strap caught once as power-up starts
      if (state == PCPS_OFF && next_state != PCPS_OFF) begin
        strap <= pins_s.freq_strap;
      end
    end
  end

  // ****************************************************************
  // Core controls and ULPI clock pin
  // ****************************************************************
  wire pll_on = state == PCPS_LOCK || state == PCPS_RUN;
  // PLL ratio from the held strap
  wire [7:0] ref_ratio = strap ? `PCPS_PLL_RATIO_26M : `PCPS_PLL_RATIO_19M2;
  // Grounded reference means the ULPI clock is the PLL reference
  wire [7:0] ratio = ref_active ? ref_ratio : `PCPS_PLL_RATIO_ULPI;

  always_comb begin
    core.active_power_state = state == PCPS_RST || pll_on ||
      state == PCPS_CHG;
    // Reset released only on the selected path
    core.internal_power_on_reset = !(state == PCPS_RST || pll_on);
    core.pll_run = pll_on;
    // One PLL ratio yields ULPI and bit clocks
    core.pll_ratio = ratio;
    core.pll_ref_is_ulpi = !ref_active;
    core.charger_fsm_start = state == PCPS_CHG;
  end

  // Stand-in for the PLL's 60 MHz output, so it toggles only once locked.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_tog <= 1'b0;
      uclk_d <= 1'b0;
    end else begin
      div_tog <= (state == PCPS_RUN) ? !div_tog : 1'b0;
      uclk_d <= uclk_s;
    end
  end

  // Pin driven only after reference activity is seen
  assign ulpi_clk_oe = ref_active;
  assign ulpi_clk_out = div_tog;
  // Direction held high until lock completes
  assign ulpi_dir = state != PCPS_RUN;

  // ****************************************************************
  // APB registers
  // ****************************************************************
  logic [3:0] otg;
  logic [1:0] ctrl_steps;
  logic ctrl_lockw;
  wire wr = psel && penable && pwrite;
  wire hit_ctrl = paddr == `PCPS_ADDR_CTRL;
  wire hit_stat = paddr == `PCPS_ADDR_STAT;
  wire hit_otg = paddr == `PCPS_ADDR_OTG;
  wire hit_cfg = paddr == `PCPS_ADDR_CFG;
  wire hit_any = hit_ctrl || hit_stat || hit_otg || hit_cfg;
  wire [31:0] stat_word = {16'h0000, state == PCPS_CHG, ulpi_dir, lock_s,
    pll_on, core.internal_power_on_reset, strap, ref_active, ulpi_clk_oe,
    1'b0, state};
  wire [31:0] rd_word = hit_ctrl ? {29'h0, ctrl_lockw, ctrl_steps} :
    hit_stat ? stat_word : hit_otg ? {28'h0, otg} :
    hit_cfg ? {24'h0, ratio} : 32'h0000_0000;

  assign rail_steps = ctrl_steps;
  assign lock_wait_en = ctrl_lockw;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // OTG defaults: host without VBUS, pulldowns on
      otg <= `PCPS_OTG_RESET;
      ctrl_steps <= 2'(`PCPS_RAIL_STEPS);
      ctrl_lockw <= 1'b1;
      prdata <= 32'h0000_0000;
    end else begin
      if (state == PCPS_OFF) begin
        otg <= `PCPS_OTG_RESET;
      end else if (wr && hit_otg) begin
        otg <= pwdata[3:0];
      end
      if (wr && hit_ctrl) begin
        ctrl_steps <= pwdata[`PCPS_CTRL_RAIL_STEPS +: 2];
        ctrl_lockw <= pwdata[`PCPS_CTRL_LOCK_TIME];
      end
      if (psel && !penable && !pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  assign otg_ctrl = otg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_dir_until_lock;
    @(posedge pclk) disable iff (!presetn)
    (state != PCPS_RUN) |-> ulpi_dir;
  endproperty
  a_dir_until_lock: assert property (p_dir_until_lock)
    else $error("Direction dropped before lock.");
  property p_run_needs_lock;
    @(posedge pclk) disable iff (!presetn)
    $rose(state == PCPS_RUN) |-> $past(lock_s) && !core.internal_power_on_reset;
  endproperty
  a_run_needs_lock: assert property (p_run_needs_lock)
    else $error("Run entered without lock.");
  property p_chg_reset_held;
    @(posedge pclk) disable iff (!presetn)
    (state == PCPS_CHG) |-> core.internal_power_on_reset && !core.pll_run;
  endproperty
  a_chg_reset_held: assert property (p_chg_reset_held)
    else $error("Charger mode released reset.");
  property p_std_gate;
    @(posedge pclk) disable iff (!presetn)
    $rose(state == PCPS_RAMP) |-> $past(std_go);
  endproperty
  a_std_gate: assert property (p_std_gate)
    else $error("Standard power-up without select.");
  property p_chg_gate;
    @(posedge pclk) disable iff (!presetn)
    $rose(state == PCPS_CRAMP) |-> $past(chg_go) && !$past(selected);
  endproperty
  a_chg_gate: assert property (p_chg_gate)
    else $error("Charger power-up without its conditions.");
  property p_clk_input;
    @(posedge pclk) disable iff (!presetn)
    !ref_active |-> !ulpi_clk_oe && core.pll_ref_is_ulpi;
  endproperty
  a_clk_input: assert property (p_clk_input)
    else $error("ULPI clock driven without reference.");
  property p_strap_hold;
    @(posedge pclk) disable iff (!presetn)
    (state != PCPS_OFF && $past(state) != PCPS_OFF) |-> $stable(strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("Strap changed while powered.");
  property p_otg_default;
    @(posedge pclk) disable iff (!presetn)
    (state == PCPS_OFF) |=> otg_ctrl == `PCPS_OTG_RESET;
  endproperty
  a_otg_default: assert property (p_otg_default)
    else $error("OTG bits not at defaults.");
  property p_ratio;
    @(posedge pclk) disable iff (!presetn)
    ref_active |-> core.pll_ratio == (strap ? `PCPS_PLL_RATIO_26M :
      `PCPS_PLL_RATIO_19M2);
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("PLL ratio does not match strap.");

  c_run: cover property (@(posedge pclk) disable iff (!presetn)
    state == PCPS_RUN);
  c_chg: cover property (@(posedge pclk) disable iff (!presetn)
    state == PCPS_CHG);
  c_out_clk: cover property (@(posedge pclk) disable iff (!presetn)
    ulpi_clk_oe && state == PCPS_RUN);
endmodule

`default_nettype wire

// ===== pcps_link_model.sv
// Link-side model: select pins, reference oscillator and ULPI input clock.
`timescale 1ns/1ns
`default_nettype none
module pcps_link_model #(
  parameter int HALF_NS = 40 // Half period of the link-side clocks
) (
  input wire logic sel_req, // Link wants the chip selected
  input wire logic use_low, // Link steers the low-active select pin
  input wire logic ref_on, // Reference oscillator fitted and running
  input wire logic dev_oe, // Device drives the ULPI clock pin
  output logic chip_select, // High-active select pin
  output logic chip_select_low, // Low-active select pin
  output logic ref_clk, // Reference clock pin
  output logic link_clk // ULPI clock driven by the link
);
  assign chip_select = use_low ? 1'h1 : sel_req;
  assign chip_select_low = use_low ? !sel_req : 1'h0;
  // The odd start offset keeps both clocks out of phase with pclk.
  initial begin
    ref_clk = 1'h0;
    link_clk = 1'h0;
    #13;
    forever begin
      #HALF_NS;
      ref_clk = ref_on ? !ref_clk : 1'h0;
      link_clk = dev_oe ? 1'h0 : !link_clk;
    end
  end
endmodule
`default_nettype wire

// ===== phy_clock_power_sequencer_tb_top.sv
// Self-checking bench of the clock and power sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "pcps_params.svh"
module phy_clock_power_sequencer_tb_top;
  import pcps_pkg::*;
  localparam int LOCK_CYC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic ulpi_clk_out, ulpi_clk_oe, ulpi_dir, pll_locked, x;
  logic ref_clk, link_clk, sel_req, use_low, ref_on, cs, cs_n;
  logic [3:0] otg_ctrl;
  pcps_pins_s drv;
  pcps_core_s core;
  wire pcps_pins_s pins;
  wire logic ulpi_pin;
  int num_errors, cmp_count, m_strap, d;
  int otg_q[$];
  assign pins = {drv[7:4], cs, cs_n, drv[1:0]};
  assign ulpi_pin = ulpi_clk_oe ? ulpi_clk_out : link_clk;
  pcps_sequencer #(.LOCK_CYC(LOCK_CYC)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .reference_clock_input(ref_clk),
    .pll_locked(pll_locked), .ulpi_clk_in(ulpi_pin),
    .ulpi_clk_out(ulpi_clk_out), .ulpi_clk_oe(ulpi_clk_oe),
    .ulpi_dir(ulpi_dir), .otg_ctrl(otg_ctrl), .core(core));
  pcps_link_model u_link (.sel_req(sel_req), .use_low(use_low),
    .ref_on(ref_on), .dev_oe(ulpi_clk_oe), .chip_select(cs),
    .chip_select_low(cs_n), .ref_clk(ref_clk), .link_clk(link_clk));
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t %s is %b", $time, m, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Requests hold until pready is seen high; no wait count is assumed.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 100) begin
      num_errors++;
      $display("[FAIL] %0t APB answer ran out", $time);
      finish_test();
    end
    @(posedge pclk);
  endtask
  task automatic wait_for(input int s);
    int n;
    logic hit;
    n = 0;
    hit = 1'h0;
    while (!hit && n < 3000) begin
      @(posedge pclk);
      n++;
      case (s)
        0: hit = (ulpi_dir === 1'h0);
        1: hit = (core.internal_power_on_reset === 1'h0);
        2: hit = (core.charger_fsm_start === 1'h1);
        default: hit = (ulpi_clk_oe === 1'h1);
      endcase
    end
    if (!hit) begin
      num_errors++;
      $display("[FAIL] %0t wait %0d ran out", $time, s);
      finish_test();
    end
  endtask
  task automatic do_reset();
    presetn <= 1'h0;
    pll_locked <= 1'h0;
    drv <= '0;
    sel_req <= 1'h0;
    cyc(20);
    chk_bit(ulpi_dir, 1'h1, "dir");
    chk_bit(ulpi_clk_oe, 1'h0, "oe");
    chk_word({28'h0, otg_ctrl}, {28'h0, `PCPS_OTG_RESET});
    chk_bit(core.pll_run, 1'h0, "pll");
    presetn <= 1'h1;
    cyc(1);
  endtask
  // Standard power-up; the model expects the strap latched here.
  task automatic power_up();
    drv.vbat_ok <= 1'h1;
    drv.vio_ok <= 1'h1;
    sel_req <= 1'h1;
    m_strap = drv.freq_strap;
    wait_for(1);
    // The wait returns in the single PCPS_RST cycle, with reset released; PCPS_LOCK follows.
    cyc(1);
    chk_bit(core.pll_run, 1'h1, "pll");
    cyc(int'(xs() % 30) + 5);
    chk_bit(ulpi_dir, 1'h1, "dir");
    pll_locked <= 1'h1;
    wait_for(0);
    chk_bit(core.active_power_state, 1'h1, "act");
    x = ulpi_clk_out;
    cyc(1);
    chk_bit(ulpi_clk_out, !x, "clk");
    apb(1'h0, `PCPS_ADDR_STAT, 32'h0);
    d = 32'h3010 | (int'(ulpi_clk_oe) * 32'h300) | (m_strap << 10);
    chk_word({16'h0, rd[15:0]}, d);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    drv = '0;
    pll_locked = 1'h0;
    sel_req = 1'h0;
    use_low = 1'h0;
    ref_on = 1'h0;
    seed = 32'h2544;
    num_errors = 0;
    cmp_count = 0;
    do_reset();
    apb(1'h0, `PCPS_ADDR_CTRL, 32'h0);
    chk_word(rd, 32'h7);
    apb(1'h1, `PCPS_ADDR_OTG, 32'h9);
    apb(1'h0, `PCPS_ADDR_OTG, 32'h0);
    chk_word(rd, 32'h6);
    apb(1'h0, 12'h010, 32'h0);
    chk_bit(err, 1'h1, "slverr");
    drv.vbat_ok <= 1'h1;
    sel_req <= 1'h1;
    cyc(80);
    chk_bit(core.internal_power_on_reset, 1'h1, "por");
    power_up();
    chk_bit(ulpi_clk_oe, 1'h0, "oe");
    chk_bit(core.pll_ref_is_ulpi, 1'h1, "ref");
    chk_word({24'h0, core.pll_ratio}, {24'h0, `PCPS_PLL_RATIO_ULPI});
    repeat (3) begin
      otg_q.push_back(int'(xs() & 32'hF));
      apb(1'h1, `PCPS_ADDR_OTG, otg_q[$]);
      apb(1'h0, `PCPS_ADDR_OTG, 32'h0);
      chk_word(rd, otg_q[$]);
      chk_word({28'h0, otg_ctrl}, otg_q.pop_front());
    end
    for (int s = 0; s < 2; s++) begin
      do_reset();
      ref_on <= 1'h1;
      drv.freq_strap <= s[0];
      wait_for(3);
      power_up();
      d = s ? `PCPS_PLL_RATIO_26M : `PCPS_PLL_RATIO_19M2;
      drv.freq_strap <= !s[0];
      cyc(10);
      chk_word({24'h0, core.pll_ratio}, d);
      apb(1'h0, `PCPS_ADDR_CFG, 32'h0);
      chk_word(rd, d);
    end
    ref_on <= 1'h0;
    do_reset();
    use_low <= 1'h1;
    drv.vbat_ok <= 1'h1;
    drv.vbus_ok <= 1'h1;
    drv.vbat_above_mntr <= 1'h1;
    drv.charger_detect_enable_low <= 1'h1;
    cyc(80);
    chk_bit(core.active_power_state, 1'h0, "act");
    drv.charger_detect_enable_low <= 1'h0;
    wait_for(2);
    chk_bit(core.internal_power_on_reset, 1'h1, "por");
    chk_bit(core.pll_run, 1'h0, "pll");
    chk_bit(core.active_power_state, 1'h1, "act");
    finish_test();
  end
endmodule
`default_nettype wire
